// [verilog/identify_words_pkg.sv]
// Constants for the identification feature word generator.
// Assumes one clock domain; straps and media pins arrive asynchronously.
// ============================================================
`default_nettype none
package identify_words_pkg;
    // ========================================================
    // Port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    // ========================================================
    // Register addresses; word addresses equal word positions
    localparam logic [7:0] ADDR_FEAT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MEDIA_STAT = 8'h01;
    localparam logic [7:0] ADDR_W81 = 8'h51;
    localparam logic [7:0] ADDR_W82 = 8'h52;
    localparam logic [7:0] ADDR_W83 = 8'h53;
    localparam logic [7:0] ADDR_W84 = 8'h54;
    localparam logic [7:0] ADDR_W85 = 8'h55;
    localparam logic [7:0] ADDR_W86 = 8'h56;
    localparam logic [7:0] ADDR_W87 = 8'h57;
    // ========================================================
    // Minor revision codes
    localparam logic [15:0] REV_NONE = 16'h0000;
    localparam logic [15:0] REV_LAST = 16'h0022;
    localparam logic [15:0] REV_RSV_A = 16'h001d;
    localparam logic [15:0] REV_RSV_B = 16'h001f;
    localparam logic [15:0] REV_RSV_C = 16'h0020;
    // ========================================================
    // Common bit positions
    localparam int unsigned B_SIG_ONE = 14;
    localparam int unsigned B_SIG_ZERO = 15;
    localparam int unsigned B_PWR_MGMT = 3;
    localparam int unsigned B_PACKET = 4;
    localparam int unsigned B_FLUSH = 12;
    localparam int unsigned B_SPINUP = 6;
    localparam int unsigned B_PUIS = 5;
    localparam int unsigned B_SERIAL = 2;
    localparam int unsigned B_STREAM = 4;
    // ========================================================
    // Bit masks of strap-driven, mirrored and control fields
    localparam logic [15:0] CAP82_MASK = 16'h77e7;
    localparam logic [15:0] CAP83_MASK = 16'h2fbf;
    localparam logic [15:0] CAP84_MASK = 16'h27ff;
    localparam logic [15:0] MIRROR85 = 16'h7604;
    localparam logic [15:0] MIRROR86 = 16'h2c87;
    localparam logic [15:0] MIRROR87 = 16'h27e3;
    localparam logic [15:0] CTRL_MASK = 16'h0fff;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ========================================================
    // Feature control register fields
    localparam int unsigned C_SMART = 0;
    localparam int unsigned C_SECURITY = 1;
    localparam int unsigned C_WCACHE = 2;
    localparam int unsigned C_LOOKAHEAD = 3;
    localparam int unsigned C_REL_INT = 4;
    localparam int unsigned C_SVC_INT = 5;
    localparam int unsigned C_APM = 6;
    localparam int unsigned C_MEDIA_STAT = 7;
    localparam int unsigned C_PUIS = 8;
    localparam int unsigned C_SETMAX = 9;
    localparam int unsigned C_AAM = 10;
    localparam int unsigned C_CARD_PT = 11;
    localparam int unsigned C_STREAM = 12; // Set by firmware once streams are configured
endpackage : identify_words_pkg
`default_nettype wire

// [verilog/identify_feature_words.sv]
// Generator of identification words 81 to 87 behind a plain register port.
// Assumes capability straps and media pins are asynchronous and static-ish;
// firmware mirrors feature-setting commands into the control register.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module identify_feature_words
    import identify_words_pkg::*;
#(
    parameter logic [15:0] MINOR_REV = REV_NONE
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output var  logic [DATA_W-1:0] rdata,
    input  wire logic [15:0]       cap82_strap,
    input  wire logic [15:0]       cap83_strap,
    input  wire logic [15:0]       cap84_strap,
    input  wire logic              media_present,
    input  wire logic              media_serial_ok,
    output var  logic [15:0]       feat_ctrl
);

    // ========================================================
    // State
    typedef struct packed {
        logic [15:0] cap82_s1;
        logic [15:0] cap82_s2;
        logic [15:0] cap83_s1;
        logic [15:0] cap83_s2;
        logic [15:0] cap84_s1;
        logic [15:0] cap84_s2;
        logic [1:0]  media_s1;
        logic [1:0]  media_s2;
        logic [15:0] ctrl;
        logic [15:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [15:0] w81;
    logic [15:0] w82;
    logic [15:0] w83;
    logic [15:0] w84;
    logic [15:0] w85;
    logic [15:0] w86;
    logic [15:0] w87;
    logic [15:0] en_eff;

    // ========================================================
    // Minor revision filter: a reserved or unknown code must never leave
    function automatic logic [15:0] legal_rev(input logic [15:0] code);
        logic [15:0] res;
        res = code;
        if (code == REV_NONE || code == 16'hffff) begin
            res = code;
        end else if (code > REV_LAST || code == REV_RSV_A ||
                     code == REV_RSV_B || code == REV_RSV_C) begin
            res = REV_NONE;
        end
        return res;
    endfunction : legal_rev

    // ========================================================
    // Effective enables: a feature without support never reads enabled in words 85 to 87; the control register reads back ungated
    always_comb begin
        en_eff = ZERO16;
        en_eff[C_SMART] = st_reg.ctrl[C_SMART] & st_reg.cap82_s2[0];
        en_eff[C_SECURITY] = st_reg.ctrl[C_SECURITY] & st_reg.cap82_s2[1];
        en_eff[C_WCACHE] = st_reg.ctrl[C_WCACHE] & st_reg.cap82_s2[5];
        en_eff[C_LOOKAHEAD] = st_reg.ctrl[C_LOOKAHEAD] & st_reg.cap82_s2[6];
        en_eff[C_REL_INT] = st_reg.ctrl[C_REL_INT] & st_reg.cap82_s2[7];
        en_eff[C_SVC_INT] = st_reg.ctrl[C_SVC_INT] & st_reg.cap82_s2[8];
        en_eff[C_APM] = st_reg.ctrl[C_APM] & st_reg.cap83_s2[3];
        en_eff[C_MEDIA_STAT] = st_reg.ctrl[C_MEDIA_STAT] & st_reg.cap83_s2[4];
        en_eff[C_PUIS] = st_reg.ctrl[C_PUIS] & st_reg.cap83_s2[B_PUIS];
        en_eff[C_SETMAX] = st_reg.ctrl[C_SETMAX] & st_reg.cap83_s2[8];
        en_eff[C_AAM] = st_reg.ctrl[C_AAM] & st_reg.cap83_s2[9];
        en_eff[C_CARD_PT] = st_reg.ctrl[C_CARD_PT] & st_reg.cap84_s2[3];
    end

    // ========================================================
    // Revision word from the parameter; support words built from synchronised straps
    always_comb begin
        w81 = legal_rev(MINOR_REV);
        // Undefined and obsolete positions are forced to zero
        w82 = st_reg.cap82_s2 & CAP82_MASK;
        w82[B_PWR_MGMT] = 1'b1;
        w82[B_PACKET] = 1'b0;
        w83 = st_reg.cap83_s2 & CAP83_MASK;
        // Spin-up need only makes sense with standby power-up supported
        w83[B_SPINUP] = st_reg.cap83_s2[B_SPINUP] & st_reg.cap83_s2[B_PUIS];
        w83[B_FLUSH] = 1'b1;
        w83[B_SIG_ONE] = 1'b1;
        w83[B_SIG_ZERO] = 1'b0;
        w84 = st_reg.cap84_s2 & CAP84_MASK;
        w84[B_SIG_ONE] = 1'b1;
        w84[B_SIG_ZERO] = 1'b0;
    end

    // ========================================================
    // Enable words: live state gated by support, mirrors elsewhere
    always_comb begin
        w85 = w82 & MIRROR85;
        w85[0] = en_eff[C_SMART];
        w85[1] = en_eff[C_SECURITY];
        w85[B_PWR_MGMT] = 1'b1;
        w85[B_PACKET] = 1'b0;
        w85[5] = en_eff[C_WCACHE];
        w85[6] = en_eff[C_LOOKAHEAD];
        w85[7] = en_eff[C_REL_INT];
        w85[8] = en_eff[C_SVC_INT];
        w86 = w83 & MIRROR86;
        w86[3] = en_eff[C_APM];
        w86[4] = en_eff[C_MEDIA_STAT];
        w86[5] = en_eff[C_PUIS];
        w86[B_SPINUP] = w83[B_SPINUP] & en_eff[C_PUIS];
        w86[8] = en_eff[C_SETMAX];
        w86[9] = en_eff[C_AAM];
        w86[B_FLUSH] = 1'b1;
        w87 = w84 & MIRROR87;
        // Serial number valid needs support, media and a good number
        w87[B_SERIAL] = w84[B_SERIAL] & st_reg.media_s2[0] &
                        st_reg.media_s2[1];
        w87[3] = en_eff[C_CARD_PT];
        w87[B_STREAM] = w84[B_STREAM] & st_reg.ctrl[C_STREAM];
        w87[B_SIG_ONE] = 1'b1;
        w87[B_SIG_ZERO] = 1'b0;
    end

    // ========================================================
    // Next state: synchronisers, control writes, registered reads
    always_comb begin
        st_next = st_reg;
        // First stages feed only the second stages
        st_next.cap82_s1 = cap82_strap;
        st_next.cap82_s2 = st_reg.cap82_s1;
        st_next.cap83_s1 = cap83_strap;
        st_next.cap83_s2 = st_reg.cap83_s1;
        st_next.cap84_s1 = cap84_strap;
        st_next.cap84_s2 = st_reg.cap84_s1;
        st_next.media_s1 = {media_serial_ok, media_present};
        st_next.media_s2 = st_reg.media_s1;
        // Firmware writes the enable state after each feature command
        if (wr && addr == ADDR_FEAT_CTRL) begin
            st_next.ctrl = wdata & (CTRL_MASK | (16'h0001 << C_STREAM));
        end
        // Read data stands only in the cycle after the strobe
        st_next.rdata = ZERO16;
        if (rd) begin
            if (addr == ADDR_FEAT_CTRL) begin
                st_next.rdata = st_reg.ctrl;
            end else if (addr == ADDR_MEDIA_STAT) begin
                st_next.rdata = {14'h0000, st_reg.media_s2};
            end else if (addr == ADDR_W81) begin
                st_next.rdata = w81;
            end else if (addr == ADDR_W82) begin
                st_next.rdata = w82;
            end else if (addr == ADDR_W83) begin
                st_next.rdata = w83;
            end else if (addr == ADDR_W84) begin
                st_next.rdata = w84;
            end else if (addr == ADDR_W85) begin
                st_next.rdata = w85;
            end else if (addr == ADDR_W86) begin
                st_next.rdata = w86;
            end else if (addr == ADDR_W87) begin
                st_next.rdata = w87;
            end
        end
    end

    // ========================================================
    // State register; straps read as absent until synchronised
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign feat_ctrl = st_reg.ctrl;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence rd_at(logic [7:0] a);
        rd && addr == a;
    endsequence

    sequence sig_ok;
        rdata[B_SIG_ZERO:B_SIG_ONE] == 2'b01;
    endsequence

    a_rev_legal: assert property (rd_at(ADDR_W81) |=>
        rdata <= REV_LAST && rdata != REV_RSV_A && rdata != REV_RSV_B &&
        rdata != REV_RSV_C || rdata == 16'hffff)
        else $error("minor revision word holds a reserved code");
    a_w83_signature: assert property (rd_at(ADDR_W83) |=> sig_ok)
        else $error("word 83 signature wrong");
    a_w84_signature: assert property (rd_at(ADDR_W84) |=> sig_ok)
        else $error("word 84 signature wrong");
    a_w87_signature: assert property (rd_at(ADDR_W87) |=> sig_ok)
        else $error("word 87 signature wrong");
    a_pwr_pkt_bits: assert property ((rd_at(ADDR_W82) or rd_at(ADDR_W85))
        |=> rdata[B_PWR_MGMT] && !rdata[B_PACKET] && !rdata[11])
        else $error("power or packet bit wrong");
    a_flush_bits: assert property ((rd_at(ADDR_W83) or rd_at(ADDR_W86))
        |=> rdata[B_FLUSH])
        else $error("flush cache bit not set");
    a_smart_follow: assert property (rd_at(ADDR_W85) |=>
        rdata[0] == ($past(st_reg.ctrl[C_SMART]) && $past(st_reg.cap82_s2[0])))
        else $error("self-monitoring enable bit does not follow control");
    a_wcache_follow: assert property (rd_at(ADDR_W85) |=>
        rdata[5] == ($past(st_reg.ctrl[C_WCACHE]) && $past(st_reg.cap82_s2[5])))
        else $error("write cache enable bit does not follow control");
    a_serial_valid: assert property (rd_at(ADDR_W87) ##1 rdata[B_SERIAL]
        |-> $past(st_reg.media_s2) == 2'b11)
        else $error("serial valid bit without valid media");
    a_reserved_84: assert property (rd_at(ADDR_W84) |=> rdata[12:11] == 2'b00)
        else $error("word 84 reserved bits set");
    a_ctrl_write: assert property (wr && addr == ADDR_FEAT_CTRL |=>
        feat_ctrl[C_APM] == $past(wdata[C_APM]))
        else $error("control write not taken");

    // ========================================================
    // Field checks: fixed bits, strap copies, enables and the port
    sequence ctrl_wr;
        wr && addr == ADDR_FEAT_CTRL;
    endsequence

    sequence serial_shown;
        rd_at(ADDR_W87) ##1 rdata[B_SERIAL];
    endsequence

    // Revision word is the parameter or, when filtered, zero
    a_rev_source: assert property (rd_at(ADDR_W81) |=>
        rdata == MINOR_REV || rdata == REV_NONE)
        else $error("minor revision word neither parameter nor zero");

    // Only the power management bit sits outside the strap field
    a_w82_fixed: assert property (rd_at(ADDR_W82) |=>
        (rdata & ~CAP82_MASK) == (16'h0001 << B_PWR_MGMT))
        else $error("word 82 undefined bit set");

    // Obsolete top bit of both power words stays clear
    a_obsolete_top: assert property ((rd_at(ADDR_W82) or rd_at(ADDR_W85))
        |=> !rdata[B_SIG_ZERO])
        else $error("obsolete bit 15 set");

    // Packet commands are never offered
    a_packet_clear: assert property ((rd_at(ADDR_W82) or rd_at(ADDR_W85))
        |=> !rdata[B_PACKET])
        else $error("packet command bit set");

    // Support fields copy the synchronised straps
    a_w82_straps: assert property (rd_at(ADDR_W82) |=>
        (rdata & CAP82_MASK) == ($past(st_reg.cap82_s2) & CAP82_MASK))
        else $error("word 82 support bits differ from straps");

    // Word 83 straps, spin-up bit excluded
    a_w83_straps: assert property (rd_at(ADDR_W83) |=>
        (rdata & CAP83_MASK) == ($past(st_reg.cap83_s2) & CAP83_MASK))
        else $error("word 83 support bits differ from straps");

    // Word 84 straps; reserved bits lie outside the mask
    a_w84_straps: assert property (rd_at(ADDR_W84) |=>
        (rdata & CAP84_MASK) == ($past(st_reg.cap84_s2) & CAP84_MASK))
        else $error("word 84 support bits differ from straps");

    // Spin-up need is only claimed with standby power-up supported
    a_w83_spinup: assert property (rd_at(ADDR_W83) |=>
        rdata[B_SPINUP] == ($past(st_reg.cap83_s2[B_SPINUP]) && $past(st_reg.cap83_s2[B_PUIS])))
        else $error("word 83 spin-up bit wrong");

    // Enabled spin-up need requires standby power-up enabled
    a_w86_spinup: assert property (rd_at(ADDR_W86) ##1 rdata[B_SPINUP] |->
        $past(st_reg.ctrl[C_PUIS]) && $past(st_reg.cap83_s2[B_PUIS]))
        else $error("spin-up flag without standby power-up enabled");

    // Security enable follows control when supported
    a_security_follow: assert property (rd_at(ADDR_W85) |=>
        rdata[1] == ($past(st_reg.ctrl[C_SECURITY]) && $past(st_reg.cap82_s2[1])))
        else $error("security enable bit does not follow control");

    // Look-ahead enable follows control when supported
    a_lookahead_follow: assert property (rd_at(ADDR_W85) |=>
        rdata[6] == ($past(st_reg.ctrl[C_LOOKAHEAD]) && $past(st_reg.cap82_s2[6])))
        else $error("look-ahead enable bit does not follow control");

    // Release and service interrupt enables as a pair
    a_intr_follow: assert property (rd_at(ADDR_W85) |=>
        rdata[8:7] == ($past(st_reg.ctrl[C_SVC_INT:C_REL_INT]) & $past(st_reg.cap82_s2[8:7])))
        else $error("interrupt enable bits do not follow control");

    // Advanced power management enable
    a_apm_follow: assert property (rd_at(ADDR_W86) |=>
        rdata[3] == ($past(st_reg.ctrl[C_APM]) && $past(st_reg.cap83_s2[3])))
        else $error("power management enable bit does not follow control");

    // Media status notification enable
    a_media_follow: assert property (rd_at(ADDR_W86) |=>
        rdata[4] == ($past(st_reg.ctrl[C_MEDIA_STAT]) && $past(st_reg.cap83_s2[4])))
        else $error("media status enable bit does not follow control");

    // Standby power-up enable
    a_puis_follow: assert property (rd_at(ADDR_W86) |=>
        rdata[5] == ($past(st_reg.ctrl[C_PUIS]) && $past(st_reg.cap83_s2[B_PUIS])))
        else $error("standby power-up enable bit does not follow control");

    // Max-address security extension enable
    a_setmax_follow: assert property (rd_at(ADDR_W86) |=>
        rdata[8] == ($past(st_reg.ctrl[C_SETMAX]) && $past(st_reg.cap83_s2[8])))
        else $error("max-address enable bit does not follow control");

    // Acoustic management enable
    a_aam_follow: assert property (rd_at(ADDR_W86) |=>
        rdata[9] == ($past(st_reg.ctrl[C_AAM]) && $past(st_reg.cap83_s2[9])))
        else $error("acoustic enable bit does not follow control");

    // Card pass-through enable
    a_card_pt_follow: assert property (rd_at(ADDR_W87) |=>
        rdata[3] == ($past(st_reg.ctrl[C_CARD_PT]) && $past(st_reg.cap84_s2[3])))
        else $error("card pass-through enable bit does not follow control");

    // Stream configured flag
    a_stream_follow: assert property (rd_at(ADDR_W87) |=>
        rdata[B_STREAM] == ($past(st_reg.ctrl[C_STREAM]) && $past(st_reg.cap84_s2[B_STREAM])))
        else $error("stream configured bit does not follow control");

    // Features that cannot be disabled mirror their support bits
    a_mirror_85: assert property (rd_at(ADDR_W85) |=>
        (rdata & MIRROR85) == ($past(st_reg.cap82_s2) & MIRROR85))
        else $error("word 85 mirrored bits differ from support");

    // Word 86 mirrors, external boot area bit included
    a_mirror_86: assert property (rd_at(ADDR_W86) |=>
        (rdata & MIRROR86) == ($past(st_reg.cap83_s2) & MIRROR86))
        else $error("word 86 mirrored bits differ from support");

    // Word 87 mirrors
    a_mirror_87: assert property (rd_at(ADDR_W87) |=>
        (rdata & MIRROR87) == ($past(st_reg.cap84_s2) & MIRROR87))
        else $error("word 87 mirrored bits differ from support");

    // A valid serial flag also needs the field to be supported
    a_serial_support: assert property (serial_shown |->
        $past(st_reg.cap84_s2[B_SERIAL]))
        else $error("serial valid bit without support");

    // Read data stands only in the cycle after a read strobe
    a_rdata_idle: assert property (!rd |=>
        rdata == ZERO16)
        else $error("read data outside its cycle");

    // Unmapped places read as zero
    a_unmapped_zero: assert property (rd && (addr > ADDR_W87 ||
        (addr > ADDR_MEDIA_STAT && addr < ADDR_W81)) |=> rdata == ZERO16)
        else $error("unmapped read returned data");

    // Control state changes only on its own write
    a_ctrl_hold: assert property (!(wr && addr == ADDR_FEAT_CTRL) |=>
        $stable(feat_ctrl))
        else $error("control register changed without a write");

    // A control write keeps every defined field and drops the rest
    a_ctrl_mask: assert property (ctrl_wr |=>
        feat_ctrl == ($past(wdata) & (CTRL_MASK | (16'h0001 << C_STREAM))))
        else $error("control write stored wrong value");

endmodule : identify_feature_words
`default_nettype wire

// [tb/host_reader.sv]
// Host adapter model: reads and writes the identification register port.
// Assumes one clock; the block answers a read in the next cycle, no stall.
`timescale 1ns/10ps
`default_nettype none
module host_reader (
    input  wire logic        clk,
    output var  logic [7:0]  addr,
    output var  logic [15:0] wdata,
    output var  logic        wr,
    output var  logic        rd,
    input  wire logic [15:0] rdata
);
    // ============================================================
    // Idle port at time zero
    initial begin
        addr  = 8'h00;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One strobe cycle; read data taken in the following cycle only
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge clk);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        wdata <= ~d; // Stale data is not left on the port
        #1 q = rdata;
    endtask : xfer
endmodule : host_reader
`default_nettype wire

// [tb/identify_feature_words_test.sv]
// Self-checking bench for the identification feature word generator.
// Assumes the host_reader model and the package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module identify_feature_words_test
    import identify_words_pkg::*;
;
    logic        clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] cap82_strap;
    logic [15:0] cap83_strap;
    logic [15:0] cap84_strap;
    logic        media_present;
    logic        media_serial_ok;
    logic [15:0] feat_ctrl;
    logic [15:0] ctrl_exp;
    int          num_errors;
    int          n_compared;

    // ============================================================
    // Design and host model
    identify_feature_words #(.MINOR_REV(16'h0022)) identify_feature_words_inst (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cap82_strap(cap82_strap), .cap83_strap(cap83_strap),
        .cap84_strap(cap84_strap), .media_present(media_present),
        .media_serial_ok(media_serial_ok), .feat_ctrl(feat_ctrl));
    host_reader host_reader_inst (
        .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    // ============================================================
    // Expected word, worked out from straps, control and media pins
    function automatic logic [15:0] exp_word(input logic [7:0] a);
        logic [15:0] w82, w83, w84, w85, w86, w87;
        w82 = (cap82_strap & 16'h77e7) | 16'h0008;
        w83 = (cap83_strap & 16'h2fbf) | 16'h5000;
        w83[6] = cap83_strap[6] & cap83_strap[5];
        w84 = (cap84_strap & 16'h27ff) | 16'h4000;
        // Control bits 0, 1 and 2 to 5 land on word 85 bits 0, 1 and 5 to 8
        w85 = (w82 & 16'h7604) | 16'h0008;
        w85[1:0] = ctrl_exp[1:0] & w82[1:0];
        w85[8:5] = ctrl_exp[5:2] & w82[8:5];
        w86 = (w83 & 16'h2c87) | 16'h1000;
        w86[5:3] = ctrl_exp[8:6] & w83[5:3];
        w86[9:8] = ctrl_exp[10:9] & w83[9:8];
        w86[6] = w83[6] & w86[5];
        w87 = (w84 & 16'h27e3) | 16'h4000;
        w87[2] = cap84_strap[2] & media_present & media_serial_ok;
        w87[3] = ctrl_exp[11] & cap84_strap[3];
        w87[4] = ctrl_exp[12] & cap84_strap[4];
        case (a)
            8'h00: return ctrl_exp;
            8'h01: return {14'h0000, media_serial_ok, media_present};
            8'h51: return 16'h0022;
            8'h52: return w82;
            8'h53: return w83;
            8'h54: return w84;
            8'h55: return w85;
            8'h56: return w86;
            8'h57: return w87;
            default: return 16'h0000;
        endcase
    endfunction : exp_word

    // ============================================================
    // Comparison, bus helpers and closing report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic chk_word(input logic [7:0] a);
        logic [15:0] q;
        host_reader_inst.xfer(1'b0, a, 16'h0000, q);
        check(q, exp_word(a));
    endtask : chk_word

    task automatic put(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        host_reader_inst.xfer(1'b1, a, d, q);
        if (a == 8'h00) ctrl_exp = d & 16'h1fff;
    endtask : put

    // Straps pass a two-flop sync, so three edges pass before checking
    task automatic set_env(input logic [15:0] p, input logic [15:0] r, input logic m);
        @(posedge clk);
        cap82_strap     <= p;
        cap83_strap     <= r;
        cap84_strap     <= p;
        media_present   <= m;
        media_serial_ok <= m;
        repeat (3) @(posedge clk);
    endtask : set_env

    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ============================================================
    // Scenarios
    task automatic run_sweep;
        logic [15:0] pat [4] = '{16'hffff, 16'h0000, 16'haaaa, 16'h5555};
        for (int i = 0; i < 8; i++) begin
            set_env(pat[i/2], pat[3-i/2], 1'b1);
            put(8'h00, (i % 2) ? 16'hffff : 16'h0000);
            check(feat_ctrl, ctrl_exp);
            chk_word(8'h51);
            chk_word(8'h52);
            chk_word(8'h53);
            chk_word(8'h54);
            chk_word(8'h55);
            chk_word(8'h56);
            chk_word(8'h57);
        end
    endtask : run_sweep

    // One control bit at a time, so a swapped field position shows
    task automatic run_ctrl_bits;
        set_env(16'hffff, 16'hffff, 1'b1);
        for (int i = 0; i < 13; i++) begin
            put(8'h00, 16'h0001 << i);
            chk_word(8'h00);
            chk_word(8'h55);
            chk_word(8'h56);
            chk_word(8'h57);
        end
    endtask : run_ctrl_bits

    task automatic run_media;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            media_present   <= i[0];
            media_serial_ok <= i[1];
            repeat (3) @(posedge clk);
            chk_word(8'h01);
            chk_word(8'h57);
        end
    endtask : run_media

    // Read-only and unmapped places; read data stands one cycle only
    task automatic run_refusals;
        put(8'h51, 16'hffff);
        put(8'h01, 16'hffff);
        chk_word(8'h00);
        chk_word(8'h51);
        chk_word(8'h01);
        chk_word(8'hff);
        chk_word(8'h50);
        @(posedge clk);
        #1 check(rdata, 16'h0000);
    endtask : run_refusals

    task automatic run_mid_reset;
        put(8'h00, 16'h1fff);
        chk_word(8'h00);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(feat_ctrl, 16'h0000);
        reset_n <= 1'b1;
        ctrl_exp = 16'h0000;
        repeat (3) @(posedge clk);
        chk_word(8'h55);
    endtask : run_mid_reset

    // ============================================================
    // Clock, reset, main sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        num_errors      = 0;
        n_compared      = 0;
        ctrl_exp        = 16'h0000;
        reset_n         = 1'b0;
        cap82_strap     = 16'h0000;
        cap83_strap     = 16'h0000;
        cap84_strap     = 16'h0000;
        media_present   = 1'b0;
        media_serial_ok = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        check(rdata, 16'h0000);
        run_sweep();
        run_ctrl_bits();
        run_media();
        run_refusals();
        run_mid_reset();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : identify_feature_words_test
`default_nettype wire
